//--- tcs_fifo.sv
`timescale 1ns/1ns
module tcs_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // fill and drain sides
  tcs_stream_if.snk s_in,
  tcs_stream_if.src s_out,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  import tcs_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic push, pop;

  // handshakes and storage read
  assign s_in.ready = (count_r != CW'(DEPTH));
  assign s_out.valid = (count_r != '0);
  assign s_out.data = mem[rd_ptr_r];
  assign o_count = count_r;
  assign push = s_in.valid & s_in.ready;
  assign pop = s_out.valid & s_out.ready;

  // pointer and level update
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // reset empties the fifo
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage array
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= s_in.data;
    end
  end

  AST_FIFO_COUNT_UP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (push && !pop) |=> (count_r == $past(count_r) + 1'b1))
    else $error("fifo level did not rise on a write");

  AST_FIFO_COUNT_DOWN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (pop && !push) |=> (count_r == $past(count_r) - 1'b1))
    else $error("fifo level did not fall on a read");
endmodule

//--- tcs_host_model.sv
`timescale 1ns/1ns
module tcs_host_model (
  // clock
  input wire logic i_core_clk,
  // host write pins
  output logic o_en,
  output logic [31:0] o_data,
  output logic o_last,
  output logic o_sup
);
  // idle host at time zero
  initial begin
    o_en = 1'b0;
    o_data = 32'h0000_0000;
    o_last = 1'b0;
    o_sup = 1'b0;
  end
  // n words; the final word rides the extra take after enable drops
  task automatic put(input int n, input logic [31:0] b, input int s, input logic f);
    for (int i = 0; i < n; i++) begin
      @(negedge i_core_clk);
      o_en = (i < n - 1);
      o_data = b + 32'(i);
      o_last = f && (i == n - 1);
      o_sup = (i == s);
    end
    @(negedge i_core_clk);
    o_data = ~o_data; // released bus shows no stale word
    o_last = 1'b0;
    o_sup = 1'b0;
  endtask
endmodule

//--- tcs_pkg.sv
package tcs_pkg;
  localparam int DATA_W = 32;
  localparam int ENT_LAST = 32;
  localparam int ENT_NOFCS = 33;
  localparam int ENTRY_W = 34;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int CFG1_NOFCS_BIT = 4;
  localparam int THR_MSB = 7;
  localparam int THR_LSB = 4;
  localparam int THR_W = 4;
  localparam int NEED_W = 5;
  localparam int THR_SHIFT = 1;
  localparam int DEFER_W = 8;
  localparam logic [NEED_W-1:0] THR_MIN_WORDS = 5'h01;
  localparam logic [THR_W-1:0] THR_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] SPACE_LIMIT = 4'h5;
  localparam logic [DEFER_W-1:0] DEFER_ONE = 8'h01;
  localparam logic [DEFER_W:0] DEFER_ROUND = 9'h001;

  typedef enum logic [1:0] {ST_IDLE, ST_DEFER1, ST_DEFER2, ST_SEND} tcs_state_t;

  // words needed in the fifo before a start: twice the field, one word when the field is zero
  function automatic logic [NEED_W-1:0] tcs_need_words(input logic [THR_W-1:0] thr);
    logic [NEED_W-1:0] need;
    need = (thr == THR_ZERO) ? THR_MIN_WORDS : (NEED_W'(thr) << THR_SHIFT);
    return need;
  endfunction

  // closing third of the defer is half of the programmed part, rounded up
  function automatic logic [DEFER_W-1:0] tcs_tail_len(input logic [DEFER_W-1:0] first);
    logic [DEFER_W:0] sum;
    sum = {1'b0, first} + DEFER_ROUND;
    return sum[DEFER_W:1];
  endfunction
endpackage

//--- tcs_stream_if.sv
`timescale 1ns/1ns
interface tcs_stream_if #(parameter int W = 32);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- tcs_tx_crc_start.sv
`timescale 1ns/1ns
module tcs_tx_crc_start (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // host write side
  input wire logic i_tx_fifo_write_strobe_enable,
  input wire logic [tcs_pkg::DATA_W-1:0] i_tx_data,
  input wire logic i_tx_last,
  input wire logic i_suppress_fcs_request,
  output logic o_tx_space,
  // configuration
  input wire logic [7:0] i_cfg1,
  input wire logic [7:0] i_cfg3,
  input wire logic [tcs_pkg::DEFER_W-1:0] i_defer_first,
  // line side
  input wire logic i_line_ready,
  output logic o_line_valid,
  output logic [tcs_pkg::DATA_W-1:0] o_line_data,
  output logic o_line_last,
  output logic o_line_append_fcs,
  output logic o_tx_start,
  output logic o_defer_first,
  output logic o_defer_second
);
  import tcs_pkg::*;

  tcs_stream_if #(.W(ENTRY_W)) wr_if ();
  tcs_stream_if #(.W(ENTRY_W)) rd_if ();

  logic we_q_r, we_q_nxt;
  logic pkt_open_r, pkt_open_nxt;
  logic nofcs_acc_r, nofcs_acc_nxt;
  logic pipe_vld_r, pipe_vld_nxt;
  logic [ENTRY_W-1:0] pipe_data_r, pipe_data_nxt;
  logic [CNT_W-1:0] pkt_cnt_r, pkt_cnt_nxt;
  tcs_state_t state_r, state_nxt;
  logic [DEFER_W-1:0] dcnt_r, dcnt_nxt;
  logic start_r, start_nxt;
  logic [CNT_W-1:0] fifo_count;
  logic accept, fcs_kill, nofcs_pkt, push_last, pop_last, thr_met;
  logic [THR_W-1:0] thr;
  logic [NEED_W-1:0] need;

  tcs_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .s_in(wr_if),
    .s_out(rd_if),
    .o_count(fifo_count)
  );

  // write pipeline: the cycle after the enable drops is still a write
  assign accept = i_tx_fifo_write_strobe_enable | we_q_r;
  assign fcs_kill = i_suppress_fcs_request | i_cfg1[CFG1_NOFCS_BIT];
  assign nofcs_pkt = nofcs_acc_r | fcs_kill;
  assign wr_if.valid = pipe_vld_r;
  assign wr_if.data = pipe_data_r;
  // keep room for the pipelined word and the trailing extra write
  assign o_tx_space = (fifo_count <= SPACE_LIMIT);

  // per packet fcs decision gathered over the whole write
  always_comb begin
    we_q_nxt = i_tx_fifo_write_strobe_enable;
    pipe_vld_nxt = accept;
    pipe_data_nxt = {nofcs_pkt, i_tx_last, i_tx_data};
    pkt_open_nxt = pkt_open_r;
    nofcs_acc_nxt = nofcs_acc_r;
    if (accept) begin
      pkt_open_nxt = !i_tx_last;
      nofcs_acc_nxt = !i_tx_last && nofcs_pkt;
    end else if (pkt_open_r && fcs_kill) begin
      nofcs_acc_nxt = 1'b1;
    end
  end

  // register the write pipeline and the per packet flag
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      we_q_r <= 1'b0;
      pipe_vld_r <= 1'b0;
      pipe_data_r <= '0;
      pkt_open_r <= 1'b0;
      nofcs_acc_r <= 1'b0;
    end else begin
      we_q_r <= we_q_nxt;
      pipe_vld_r <= pipe_vld_nxt;
      pipe_data_r <= pipe_data_nxt;
      pkt_open_r <= pkt_open_nxt;
      nofcs_acc_r <= nofcs_acc_nxt;
    end
  end

  // count of whole packets sitting in the fifo
  assign push_last = pipe_vld_r & wr_if.ready & pipe_data_r[ENT_LAST];
  assign pop_last = rd_if.valid & rd_if.ready & rd_if.data[ENT_LAST];

  always_comb begin
    pkt_cnt_nxt = pkt_cnt_r + CNT_W'(push_last) - CNT_W'(pop_last);
  end

  // register the whole packet count
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pkt_cnt_r <= '0;
    end else begin
      pkt_cnt_r <= pkt_cnt_nxt;
    end
  end

  // threshold check, redone each clock while idle
  assign thr = i_cfg3[THR_MSB:THR_LSB];
  assign need = tcs_need_words(thr);
  assign thr_met = ({1'b0, fifo_count} >= need) || (pkt_cnt_r != '0);

  // start sequencer: threshold, programmed defer, closing defer, send
  always_comb begin
    state_nxt = state_r;
    dcnt_nxt = dcnt_r;
    start_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (thr_met) begin
          state_nxt = ST_DEFER1;
          dcnt_nxt = i_defer_first;
        end
      end
      ST_DEFER1: begin
        if (dcnt_r <= DEFER_ONE) begin
          state_nxt = ST_DEFER2;
          dcnt_nxt = tcs_tail_len(i_defer_first);
        end else begin
          dcnt_nxt = dcnt_r - 1'b1;
        end
      end
      ST_DEFER2: begin
        if (dcnt_r <= DEFER_ONE) begin
          state_nxt = ST_SEND;
          start_nxt = 1'b1;
        end else begin
          dcnt_nxt = dcnt_r - 1'b1;
        end
      end
      ST_SEND: begin
        if (pop_last) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // register the start sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      dcnt_r <= '0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dcnt_r <= dcnt_nxt;
      start_r <= start_nxt;
    end
  end

  // line side drain
  assign rd_if.ready = (state_r == ST_SEND) & i_line_ready;
  assign o_line_valid = (state_r == ST_SEND) & rd_if.valid;
  assign o_line_data = rd_if.data[DATA_W-1:0];
  assign o_line_last = rd_if.data[ENT_LAST];
  assign o_line_append_fcs = rd_if.data[ENT_LAST] & !rd_if.data[ENT_NOFCS];
  assign o_tx_start = start_r;
  assign o_defer_first = (state_r == ST_DEFER1);
  assign o_defer_second = (state_r == ST_DEFER2);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_we_drop;
    i_tx_fifo_write_strobe_enable ##1 !i_tx_fifo_write_strobe_enable;
  endsequence

  sequence s_defer_three;
    (state_r == ST_DEFER1) [*3] ##1 (state_r == ST_DEFER2);
  endsequence

  // whole defer for a programmed length of four: four, then two, then send
  sequence s_split_four;
    (state_r == ST_DEFER1) [*4] ##1 (state_r == ST_DEFER2) [*2] ##1 (state_r == ST_SEND);
  endsequence

  // whole defer for a programmed length of three: three, then two, then send
  sequence s_split_three;
    (state_r == ST_DEFER1) [*3] ##1 (state_r == ST_DEFER2) [*2] ##1 (state_r == ST_SEND);
  endsequence

  AST_CFG_FORCES_NOFCS: assert property (
    (accept && i_cfg1[CFG1_NOFCS_BIT]) |=> pipe_data_r[ENT_NOFCS])
    else $error("config bit did not suppress fcs");

  AST_PIN_MARKS_NOFCS: assert property (
    (accept && i_suppress_fcs_request) |=> (pipe_vld_r && pipe_data_r[ENT_NOFCS]))
    else $error("request pin did not suppress fcs");

  AST_CLEAN_KEEPS_FCS: assert property (
    (accept && i_tx_last && !fcs_kill && !nofcs_acc_r) |=> !pipe_data_r[ENT_NOFCS])
    else $error("clean packet lost its fcs");

  AST_EXTRA_WRITE: assert property (
    s_we_drop |=> pipe_vld_r)
    else $error("trailing write after enable drop was lost");

  AST_ONLY_ONE_EXTRA: assert property (
    s_we_drop ##1 !i_tx_fifo_write_strobe_enable |=> !pipe_vld_r)
    else $error("more than one write after enable drop");

  AST_HOLD_BELOW_THR: assert property (
    (state_r == ST_IDLE && !thr_met) |=> (state_r == ST_IDLE))
    else $error("start left idle below threshold");

  AST_ZERO_THR_ONE_WORD: assert property (
    (state_r == ST_IDLE && thr == THR_ZERO && fifo_count != '0) |=> (state_r == ST_DEFER1))
    else $error("zero threshold did not start on one word");

  AST_SEND_AFTER_TAIL: assert property (
    $rose(state_r == ST_SEND) |-> ($past(state_r) == ST_DEFER2) && o_tx_start)
    else $error("send entered without closing defer");

  AST_FIRST_PERIOD_LEN: assert property (
    (state_r == ST_IDLE && thr_met && i_defer_first == 8'h03) |=> s_defer_three)
    else $error("programmed defer period length wrong");

  AST_NO_OVERRUN: assert property (
    pipe_vld_r |-> wr_if.ready)
    else $error("write arrived with the fifo full");

  // reset release, start pulse and defer ordering
  AST_RESET_CLEAN: assert property (
    $rose(i_rst_n) |-> (state_r == ST_IDLE && fifo_count == '0 &&
      pkt_cnt_r == '0 && !o_tx_start))
    else $error("state not cleared after reset");

  AST_START_ONE_PULSE: assert property (
    o_tx_start |=> !o_tx_start)
    else $error("start pulse longer than one cycle");

  AST_START_IN_SEND: assert property (
    o_tx_start |-> (state_r == ST_SEND))
    else $error("start pulse outside send");

  AST_DEFER1_EXIT: assert property (
    (state_r == ST_DEFER1) |=> (state_r == ST_DEFER1 || state_r == ST_DEFER2))
    else $error("programmed defer left to a wrong state");

  AST_DEFER2_EXIT: assert property (
    (state_r == ST_DEFER2) |=> (state_r == ST_DEFER2 || state_r == ST_SEND))
    else $error("closing defer left to a wrong state");

  AST_SPLIT_FOUR: assert property (
    (state_r == ST_IDLE && thr_met && i_defer_first == 8'h04) |=> s_split_four)
    else $error("defer split wrong for length four");

  AST_SPLIT_THREE: assert property (
    (state_r == ST_IDLE && thr_met && i_defer_first == 8'h03) |=> s_split_three)
    else $error("defer split wrong for length three");

  AST_SEND_WAITS: assert property (
    (state_r == ST_SEND && !pop_last) |=> (state_r == ST_SEND))
    else $error("send left before the last word");

  // threshold against the fifo level
  AST_VALID_ONLY_SEND: assert property (
    o_line_valid |-> (state_r == ST_SEND))
    else $error("word offered before the start sequence");

  AST_BELOW_TWICE_HOLDS: assert property (
    (state_r == ST_IDLE && pkt_cnt_r == '0 && thr != THR_ZERO &&
      {1'b0, fifo_count} < ({1'b0, thr} << THR_SHIFT)) |=> (state_r == ST_IDLE))
    else $error("start left idle below twice the field");

  AST_TWICE_STARTS: assert property (
    (state_r == ST_IDLE && thr != THR_ZERO &&
      {1'b0, fifo_count} >= ({1'b0, thr} << THR_SHIFT)) |=> (state_r == ST_DEFER1))
    else $error("start not begun at twice the field");

  AST_LAST_POP_IDLE: assert property (
    (state_r == ST_SEND && pop_last) |=> (state_r == ST_IDLE))
    else $error("threshold not rechecked after a packet");

  AST_EMPTY_NO_VALID: assert property (
    (fifo_count == '0) |-> !o_line_valid)
    else $error("word offered from an empty fifo");

  AST_PKT_CNT_BOUND: assert property (
    pkt_cnt_r <= fifo_count)
    else $error("more whole packets than words in the fifo");

  // fcs flag handling
  AST_FCS_ON_LAST_ONLY: assert property (
    (o_line_valid && o_line_append_fcs) |-> o_line_last)
    else $error("fcs request on a word that is not last");

  AST_ACC_CLEARS: assert property (
    (accept && i_tx_last) |=> !nofcs_acc_r)
    else $error("fcs flag leaked into the next packet");

  AST_ACC_CARRIED: assert property (
    (accept && nofcs_acc_r) |=> pipe_data_r[ENT_NOFCS])
    else $error("gathered fcs flag not carried with the word");

  // write pipeline and room
  AST_NO_TAKE_NO_WRITE: assert property (
    !accept |=> !pipe_vld_r)
    else $error("fifo write without a take");

  AST_FULL_NO_SPACE: assert property (
    (fifo_count > SPACE_LIMIT) |-> !o_tx_space)
    else $error("space shown with too little room");

  AST_FIFO_BOUND: assert property (
    fifo_count <= CNT_W'(FIFO_DEPTH))
    else $error("fifo level above its depth");
endmodule

//--- tcs_tx_crc_start_tb.sv
`timescale 1ns/1ns
module tcs_tx_crc_start_tb;
  import tcs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rdy = 1'b0;
  logic en, last, sup, space, lv, ll, lf, st, d1, d2;
  logic [DATA_W-1:0] data, ld;
  logic [7:0] cfg1 = 8'h00;
  logic [7:0] cfg3 = 8'h00;
  logic [DEFER_W-1:0] dfr = 8'h04;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  // host side partner and device
  tcs_host_model i_tcs_host_model (.i_core_clk(clk), .o_en(en), .o_data(data),
    .o_last(last), .o_sup(sup));
  tcs_tx_crc_start i_tcs_tx_crc_start (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_tx_fifo_write_strobe_enable(en), .i_tx_data(data), .i_tx_last(last),
    .i_suppress_fcs_request(sup), .o_tx_space(space), .i_cfg1(cfg1), .i_cfg3(cfg3),
    .i_defer_first(dfr), .i_line_ready(rdy), .o_line_valid(lv), .o_line_data(ld),
    .o_line_last(ll), .o_line_append_fcs(lf), .o_tx_start(st), .o_defer_first(d1),
    .o_defer_second(d2));

  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // single exit point of the run
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // length of both defer periods and the start pulse after them
  task automatic meas(input int e1, input int e2);
    int k = 0;
    int a = 0;
    int b = 0;
    while (d1 !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    while (d1 === 1'b1 && a < 300) begin
      @(negedge clk);
      a++;
    end
    while (d2 === 1'b1 && b < 300) begin
      @(negedge clk);
      b++;
    end
    chk("defer1_len", a, e1);
    chk("defer2_len", b, e2);
    chk("tx_start", st, 1'b1);
  endtask

  // drain n words from the line side and check them
  task automatic rx(input int n, input logic [31:0] b, input logic f);
    int k;
    rdy = 1'b1;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (lv !== 1'b1 && k < 100) begin
        @(negedge clk);
        k++;
      end
      chk("line_data", ld, b + 32'(i));
      chk("line_last", ll, i == n - 1);
      if (i == n - 1) chk("append_fcs", lf, f);
      @(negedge clk);
    end
    rdy = 1'b0;
    chk("drained", lv, 1'b0);
  endtask

  // every pin and config combination, pin high in one word only
  task automatic t_fcs();
    for (int c = 0; c < 4; c++) begin
      cfg1[CFG1_NOFCS_BIT] = c[1];
      fork
        i_tcs_host_model.put(2, 32'h0000_0100 + 32'(c), c[0] ? 0 : -1, 1'b1);
        meas(4, 2);
      join
      rx(2, 32'h0000_0100 + 32'(c), c == 0);
    end
    cfg1 = 8'h00;
  endtask

  // field 3 holds start until six words, low bits ignored
  task automatic t_thr();
    cfg3 = 8'h3f;
    dfr = 8'h03;
    i_tcs_host_model.put(5, 32'h0000_0200, -1, 1'b0);
    repeat (12) @(negedge clk);
    chk("held_defer", d1, 1'b0);
    chk("held_valid", lv, 1'b0);
    chk("space_at5", space, 1'b1);
    fork
      i_tcs_host_model.put(2, 32'h0000_0205, -1, 1'b1);
      meas(3, 2);
    join
    chk("space_at7", space, 1'b0);
    rx(7, 32'h0000_0200, 1'b1);
    chk("space_empty", space, 1'b1);
    cfg3 = 8'h00;
  endtask

  // reset in mid-run empties the fifo and stops the start sequence
  task automatic t_rst();
    i_tcs_host_model.put(3, 32'h0000_0300, -1, 1'b1);
    repeat (3) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk("rst_valid", lv, 1'b0);
    chk("rst_space", space, 1'b1);
    chk("rst_defer", d1 | d2 | st, 1'b0);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    chk("post_rst_idle", lv, 1'b0);
  endtask

  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_fcs();
    t_thr();
    t_rst();
    tally_and_finish();
  end
endmodule
